// ===== logic/mblh_ctrl.sv
// Controller end: queues load requests, runs loads, drives busy.
// Assumes host logic on the same clock drives the interface.
`timescale 1ns/10ps
`default_nettype none
module mblh_ctrl #(
   parameter int LOAD_CYC = mblh_pkg::LOAD_CYC_DEFAULT
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   mblh_if.ctrl link,
   output logic loading,
   output logic [2:0] load_op,
   output logic buf_overrun
);
   typedef enum logic [1:0] {MBLH_IDLE, MBLH_LOAD} mblh_st_t;
   typedef struct packed {
      mblh_st_t st;
      logic busy_n;
      logic req_d;
      logic pend;
      logic [2:0] op_rx;
      logic [2:0] op_pend;
      logic [2:0] op_run;
      logic [15:0] cnt;
      logic [1:0] full;
      logic rx_open;
      logic ovr;
      logic run;
   } mblh_ctrl_t;
   mblh_ctrl_t s_r, s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.req_d = link.block_load_request;
      // ****************************************
      // Receive buffer
      // ****************************************
      if (link.ctrl_valid) begin
         s_nxt.op_rx = link.ctrl_op;
         // overrun flag when both buffers full
         // Two buffers held means a third block has nowhere to land
         if (s_r.full == 2'h2) begin
            s_nxt.ovr = 1'b1;
         end
      end
      if (link.block_load_request && !s_r.req_d) begin
         s_nxt.pend = 1'b1;
         s_nxt.op_pend = link.ctrl_valid ? link.ctrl_op : s_r.op_rx;
         s_nxt.full = s_r.full + 2'h1;
      end
      case (s_r.st)
         MBLH_IDLE: begin
            if (s_r.pend) begin
               // request ends block, run its op
               s_nxt.op_run = s_r.op_pend;
               s_nxt.cnt = 16'(LOAD_CYC);
               s_nxt.busy_n = 1'b0;
               s_nxt.run = 1'b1;
               s_nxt.st = MBLH_LOAD;
               if (!(link.block_load_request && !s_r.req_d)) begin
                  s_nxt.pend = 1'b0;
               end
            end
         end
         MBLH_LOAD: begin
            if (s_r.cnt <= 16'h0001) begin
               s_nxt.busy_n = 1'b1;
               s_nxt.run = 1'b0;
               s_nxt.st = MBLH_IDLE;
               s_nxt.full = s_nxt.full - 2'h1;
            end else begin
               s_nxt.cnt = s_r.cnt - 16'h0001;
            end
         end
         default: begin
            s_nxt.st = MBLH_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '{st: MBLH_IDLE, busy_n: 1'b1, full: mblh_pkg::BUF_RESET, default: '0};
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end
   assign link.block_loading_busy_n = s_r.busy_n;
   assign loading = s_r.run;
   assign load_op = s_r.op_run;
   assign buf_overrun = s_r.ovr;
endmodule : mblh_ctrl
`default_nettype wire

// ===== logic/mblh_host.sv
// Host end: frames a block, waits channels, setup, then requests.
// Assumes the controller on the same clock.
`timescale 1ns/10ps
`default_nettype none
module mblh_host (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   mblh_if.host link,
   input wire logic start,
   input wire logic [2:0] op,
   input wire logic [3:0] chan_done,
   input wire logic load_ready,
   output logic idle
);
   typedef enum logic [2:0] {MBLH_H_IDLE, MBLH_H_DATA, MBLH_H_SETUP, MBLH_H_REQ, MBLH_H_WAIT} mblh_hst_t;
   typedef struct packed {
      mblh_hst_t st;
      logic req;
      logic cv;
      logic [2:0] op;
      logic [3:0] seen;
      logic [3:0] cnt;
      logic busy_d;
      logic [3:0] cvld;
      logic [3:0] clast;
      logic idl;
   } mblh_host_t;
   mblh_host_t s_r, s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.cv = 1'b0;
      s_nxt.busy_d = link.block_loading_busy_n;
      s_nxt.clast = 4'h0;
      case (s_r.st)
         MBLH_H_IDLE: begin
            if (start) begin
               s_nxt.cv = 1'b1;
               s_nxt.op = op;
               s_nxt.seen = 4'h0;
               s_nxt.cvld = (op == mblh_pkg::OP_LOAD) ? 4'hf : 4'h0;
               s_nxt.st = MBLH_H_DATA;
            end
         end
         MBLH_H_DATA: begin
            // channels may finish on different cycles
            s_nxt.seen = s_r.seen | chan_done;
            s_nxt.cvld = s_r.cvld & ~chan_done;
            s_nxt.clast = s_r.cvld & chan_done;
            // clear and set carry no data
            if ((s_nxt.seen == 4'hf) || (s_r.op != mblh_pkg::OP_LOAD)) begin
               s_nxt.cnt = 4'(mblh_pkg::REQ_SETUP_CYC);
               s_nxt.st = MBLH_H_SETUP;
            end
         end
         MBLH_H_SETUP: begin
            if (s_r.cnt != 4'h0) begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end else if (load_ready) begin
               // request may wait for system ready
               s_nxt.req = 1'b1;
               s_nxt.st = MBLH_H_REQ;
            end
         end
         MBLH_H_REQ: begin
            s_nxt.req = 1'b0;
            s_nxt.st = MBLH_H_WAIT;
         end
         MBLH_H_WAIT: begin
            // wait for busy rising before next block
            if (link.block_loading_busy_n && !s_r.busy_d) begin
               s_nxt.st = MBLH_H_IDLE;
            end
         end
         default: begin
            s_nxt.st = MBLH_H_IDLE;
         end
      endcase
      s_nxt.idl = (s_nxt.st == MBLH_H_IDLE);
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '{st: MBLH_H_IDLE, busy_d: 1'b1, idl: 1'b1, default: '0};
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end
   assign link.block_load_request = s_r.req;
   assign link.ctrl_valid = s_r.cv;
   assign link.ctrl_op = s_r.op;
   assign link.chan_valid = s_r.cvld;
   assign link.chan_last = s_r.clast;
   assign idle = s_r.idl;
endmodule : mblh_host
`default_nettype wire

// ===== logic/mblh_if.sv
// Handshake wires between host logic and the controller.
// Assumes both ends on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface mblh_if;
   logic block_load_request;
   logic block_loading_busy_n;
   logic [3:0] chan_valid;
   logic [3:0] chan_last;
   logic ctrl_valid;
   logic [2:0] ctrl_op;
   modport host (output block_load_request, input block_loading_busy_n,
      output chan_valid, output chan_last, output ctrl_valid, output ctrl_op);
   modport ctrl (input block_load_request, output block_loading_busy_n,
      input chan_valid, input chan_last, input ctrl_valid, input ctrl_op);
endinterface : mblh_if
`default_nettype wire

// ===== logic/mblh_pkg.sv
// Constants shared by both ends of the block-load handshake.
// Assumes a single 10 MHz clock shared by host and controller.
//
// Contract
// - Host drives load request; controller only receives.
// - Request ends block, runs its control operation.
// - Host waits until all four channels finish.
// - Request at least 300ns after transfer end.
// - Block opens with control word, ends request.
// - Dataless clear/set operations still need request.
// - Request during busy is held, started later.
// - Controller holds two block buffers.
// - Busy rises on completion; host waits it.
// - Host may delay request until system ready.
// - Busy goes low when load starts.
`default_nettype none
package mblh_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int REQ_SETUP_NS = 300;
   // Least time rounds up
   localparam int REQ_SETUP_CYC = (REQ_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NUM_CHANNELS = 4;
   localparam int LOAD_CYC_DEFAULT = 16;
   localparam int OP_WIDTH = 3;
   // ****************************************
   // Operation codes
   // ****************************************
   localparam logic [2:0] OP_LOAD = 3'h0;
   localparam logic [2:0] OP_CLEAR = 3'h1;
   localparam logic [2:0] OP_SET = 3'h2;
   localparam logic [1:0] BUF_RESET = 2'h0;
endpackage : mblh_pkg
`default_nettype wire

// ===== sim/mblh_chk.sv
// Checker on the handshake wires between host and controller.
// Assumes one clock; LOAD_CYC matches the controller instance.
// The run-length sequence is written for a LOAD_CYC of 4.
`timescale 1ns/10ps
`default_nettype none
module mblh_chk #(
   parameter int LOAD_CYC = mblh_pkg::LOAD_CYC_DEFAULT
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic block_load_request,
   input wire logic block_loading_busy_n,
   input wire logic ctrl_valid,
   input wire logic [3:0] chan_valid,
   input wire logic [3:0] chan_last,
   input wire logic [2:0] ctrl_op
);
   // ****
   // Helpers: low-time count and open block
   // ****
   logic [7:0] low_r;
   logic open_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_r <= 8'h00;
         open_r <= 1'b0;
      end else begin
         low_r <= block_loading_busy_n ? 8'h00 : low_r + 8'h01;
         open_r <= ctrl_valid | (open_r & ~block_load_request);
      end
   end
   sequence s_go;
      $rose(block_load_request) && block_loading_busy_n;
   endsequence
   sequence s_run;
      !block_loading_busy_n [*4] ##1 block_loading_busy_n;
   endsequence
   a_req_pulse: assert property (block_load_request |=> !block_load_request)
      else $error("request longer than one cycle");
   a_load_start: assert property (s_go |-> ##[1:3] $fell(block_loading_busy_n))
      else $error("busy did not fall after request");
   a_run_len: assert property ($fell(block_loading_busy_n) |-> s_run)
      else $error("busy low time wrong");
   a_low_count: assert property ($rose(block_loading_busy_n) |-> low_r == LOAD_CYC)
      else $error("busy rose at wrong count");
   a_fall_cause: assert property ($fell(block_loading_busy_n)
      |-> $past(block_load_request, 2) || !$past(block_loading_busy_n, 2))
      else $error("load started without request");
   a_word_first: assert property (block_load_request |-> open_r)
      else $error("request without control word");
   a_setup_gap: assert property (block_load_request
      |-> !$past(ctrl_valid) && !$past(ctrl_valid, 2) && !$past(ctrl_valid, 3))
      else $error("request setup too short");
   a_data_gap: assert property (block_load_request
      |-> $past(chan_last) == 4'h0 && $past(chan_last, 2) == 4'h0 && $past(chan_last, 3) == 4'h0)
      else $error("request too soon after last data");
   a_chan_idle: assert property (block_load_request |-> chan_valid == 4'h0)
      else $error("request before all channels finished");
   a_free_first: assert property (ctrl_valid |-> block_loading_busy_n)
      else $error("block sent while busy");
   a_op_legal: assert property (ctrl_valid |-> ctrl_op <= 3'h2)
      else $error("reserved op code");
endmodule : mblh_chk
`default_nettype wire

// ===== sim/mblh_tb.sv
// Bench: both ends joined, one block each of clear and set, two blocks of load.
// Assumes 10 MHz clock; short loads keep the run brief.
`timescale 1ns/10ps
`default_nettype none
module mblh_tb;
   logic clk = 1'b0, reset_n = 1'b0, start = 1'b0, load_ready = 1'b0, idle, loading, buf_overrun;
   logic [2:0] op = 3'h0, load_op, n_req = 3'h0;
   logic [3:0] chan_done = 4'h0;
   int failures = 0, n_tests = 0, cyc = 0;
   mblh_if lnk();
   mblh_ctrl #(.LOAD_CYC(4)) mblh_ctrl_inst (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .link(lnk.ctrl),
      .loading(loading), .load_op(load_op), .buf_overrun(buf_overrun));
   mblh_host mblh_host_inst (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .link(lnk.host), .start(start),
      .op(op), .chan_done(chan_done), .load_ready(load_ready), .idle(idle));
   mblh_chk #(.LOAD_CYC(4)) mblh_chk_inst (.clk(clk), .reset_n(reset_n), .ctrl_op(lnk.ctrl_op),
      .block_load_request(lnk.block_load_request), .ctrl_valid(lnk.ctrl_valid),
      .block_loading_busy_n(lnk.block_loading_busy_n), .chan_valid(lnk.chan_valid),
      .chan_last(lnk.chan_last));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (lnk.block_load_request === 1'b1) n_req++;
      if (cyc == 1500) begin
         failures++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (failures == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // Staggered channel ends; request may only follow the last one
   task automatic blk(input logic [2:0] o, input int hold);
      logic [2:0] r;
      r = n_req;
      @(negedge clk);
      start = 1'b1;
      op = o;
      load_ready = (hold == 0);
      @(negedge clk);
      start = 1'b0;
      if (o === mblh_pkg::OP_LOAD) for (int c = 0; c < 4; c++) begin
         repeat (3) @(negedge clk);
         chk("req_early", r, n_req);
         chan_done = 4'h1 << c;
         @(negedge clk);
         chan_done = 4'h0;
      end
      repeat (hold) @(negedge clk);
      if (hold > 0) chk("req_held", r, n_req);
      load_ready = 1'b1;
      for (int i = 0; i < 30 && loading !== 1'b1; i++) @(negedge clk);
      chk("loading", 3'h1, {2'h0, loading});
      chk("busy_low", 3'h0, {2'h0, lnk.block_loading_busy_n});
      chk("load_op", o, load_op);
      for (int i = 0; i < 30 && idle !== 1'b1; i++) @(negedge clk);
      chk("idle", 3'h1, {2'h0, idle});
      chk("req_count", r + 3'h1, n_req);
      chk("busy_free", 3'h1, {2'h0, lnk.block_loading_busy_n});
   endtask : blk
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      blk(mblh_pkg::OP_LOAD, 0);
      blk(mblh_pkg::OP_CLEAR, 5);
      blk(mblh_pkg::OP_SET, 0);
      blk(mblh_pkg::OP_LOAD, 12);
      chk("overrun", 3'h0, {2'h0, buf_overrun});
      stop_test();
   end
endmodule : mblh_tb
`default_nettype wire
